// *** shared/ecph_pkg.sv ***
// Shared constants and types for the ECP parallel port handshake engine
package ecph_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;

  // Minimums round up to whole cycles
  localparam int unsigned FIFO_SETUP_NS  = 600;
  localparam int unsigned FIFO_PULSE_NS  = 600;
  localparam int unsigned FIFO_HOLD_NS   = 450;
  localparam int unsigned FIFO_GAP_NS    = 680;
  localparam int unsigned FIFO_TAIL_NS   = 80;
  // One delay serves every 80..180/200 ns window: 100 ns plus one or two register cycles stays inside
  localparam int unsigned ECP_DELAY_NS   = 100;
  // Debounce window must fall in 75..130 ns
  localparam int unsigned FILTER_NS      = 100;

  localparam int unsigned FIFO_SETUP_CYC = (FIFO_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FIFO_PULSE_CYC = (FIFO_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FIFO_HOLD_CYC  = (FIFO_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FIFO_GAP_CYC   = (FIFO_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FIFO_TAIL_CYC  = (FIFO_TAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ECP_DELAY_CYC  = (ECP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FILTER_CYC     = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned CNT_W = 5;

  // ----------------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] MODE_COMPAT = 3'h0;
  localparam logic [2:0] MODE_ECP    = 3'h3;
  localparam logic [2:0] MODE_FIFO   = 3'h5;

  // ----------------------------------------------------------------------
  // Reset values of the pins
  // ----------------------------------------------------------------------
  localparam logic       STROBE_N_RST   = 1'h1;
  localparam logic       HOST_ACK_N_RST = 1'h1;
  localparam logic [7:0] DATA_RST       = 8'h00;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       cmd;
    logic [7:0] data;
  } ecph_word_t;

  typedef struct packed {
    logic [7:0] data_out;
    logic       data_oe;
    logic       strobe_n_out;
    logic       strobe_n_oe;
    logic       autofd_n_out;
    logic       autofd_n_oe;
  } ecph_pins_t;

  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_F_SETUP  = 7'h02,
    ST_F_STROBE = 7'h04,
    ST_F_HOLD   = 7'h08,
    ST_E_STROBE = 7'h10,
    ST_E_REL    = 7'h20,
    ST_R_ACK    = 7'h40
  } ecph_state_t;

endpackage : ecph_pkg

// *** hw/ecph_filter.sv ***
// Synchroniser and debounce filter for one handshake input from the cable
module ecph_filter #(
  parameter int unsigned STABLE_CYC = 4,
  parameter logic        RST_VAL    = 1'h0
) (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic raw,
  output logic      filt
);

  logic       sync_a;
  logic       sync_b;
  logic [3:0] run;

  // ----------------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sync_a <= RST_VAL;
      sync_b <= RST_VAL;
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------------------------------------
  // Debounce
  // ----------------------------------------------------------------------
  // Any bounce restarts the count, so ringing on the cable never passes
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      run  <= 4'h0;
      filt <= RST_VAL;
    end else if (sync_b == filt) begin
      run <= 4'h0;
    end else if (run == 4'(STABLE_CYC - 1)) begin
      run  <= 4'h0;
      filt <= sync_b;
    end else begin
      run <= run + 4'h1;
    end
  end

endmodule : ecph_filter

// *** hw/ecph_engine.sv ***
// Handshake engine of the multi-mode parallel port: FIFO forward, ECP forward and ECP reverse
// Function
// R01: ECP mode drives data and handshake outputs push-pull.
// R02: Compatible mode uses open-collector controls; switch to push-pull without glitches.
// R03: FIFO mode: data valid at least 600 ns before strobe asserts.
// R04: FIFO mode: strobe stays asserted at least 600 ns.
// R05: FIFO mode: at least 680 ns from busy inactive to next strobe.
// R06: FIFO mode: hold data 450 ns and until 80 ns after busy inactive.
// R07: FIFO mode: with nothing pending, last byte stays on the data lines.
// R08: Peripheral raises busy within 500 ns of strobe.
// R09: ECP forward: strobe 80 to 200 ns after busy deasserts.
// R10: ECP forward: release strobe 80 to 180 ns after busy recognised asserted.
// R11: ECP forward: change data and command flag 80 to 180 ns after busy deasserts.
// R12: Forward upper limits apply only while data waits in the FIFO.
// R13: Busy transition valid only after stable 75 to 130 ns.
// R14: Peripheral asserts busy after strobe, releases it after strobe releases.
// R15: Reverse: raise host ack 80 to 200 ns after peripheral ack, if room and no terminal count.
// R16: Reverse: drop host ack 80 to 200 ns after peripheral ack releases.
// R17: Reverse: stall with host ack low while no room or terminal count seen.
// R18: Peripheral ack change accepted only after stable 75 to 130 ns.
// R19: Peripheral sets data before ack, follows host ack in its handshake.
// R20: Peripheral keeps data until host ack is reasserted low.
// R21: FIFO mode ignores the ack input and paces on busy only.
// R22: Forward idle strobe high; reverse idle host ack low.
// R23: Host clock is strobe, peripheral ack is busy, host ack is autofeed.
// R24: All delays counted in system clock cycles, minimums rounded up.
module ecph_engine (
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  input  wire logic [2:0]         mode,
  input  wire logic               reverse,
  input  wire logic               tx_valid,
  input  wire ecph_pkg::ecph_word_t tx_word,
  output logic                    tx_ready,
  output logic                    rx_valid,
  output ecph_pkg::ecph_word_t    rx_word,
  input  wire logic               rx_room,
  input  wire logic               term_count,
  input  wire logic [7:0]         port_data_lines_in,
  input  wire logic               busy_in,
  input  wire logic               ack_n_in,
  output ecph_pkg::ecph_pins_t    pins,
  output logic                    push_pull,
  output logic                    engine_idle
);

  ecph_pkg::ecph_state_t state;
  logic [ecph_pkg::CNT_W-1:0] cnt;
  logic [ecph_pkg::CNT_W-1:0] busy_lo_cnt;
  logic       busy_f;
  logic       ack_n_f;
  logic [7:0] data_sync_a;
  logic [7:0] data_sync_b;
  logic       strobe_n;
  logic       host_ack_n;
  logic [7:0] data_q;
  // Autofeed level of the current word
  logic       cmd_q;
  logic [2:0] act_mode;
  logic       act_rev;
  logic       cnt_done;
  logic       is_fifo;
  logic       is_ecp_fwd;
  logic       is_ecp_rev;

  localparam logic [ecph_pkg::CNT_W-1:0] SETUP_C = ecph_pkg::CNT_W'(ecph_pkg::FIFO_SETUP_CYC);
  localparam logic [ecph_pkg::CNT_W-1:0] PULSE_C = ecph_pkg::CNT_W'(ecph_pkg::FIFO_PULSE_CYC);
  localparam logic [ecph_pkg::CNT_W-1:0] HOLD_C  = ecph_pkg::CNT_W'(ecph_pkg::FIFO_HOLD_CYC);
  localparam logic [ecph_pkg::CNT_W-1:0] GAP_C   = ecph_pkg::CNT_W'(ecph_pkg::FIFO_GAP_CYC);
  localparam logic [ecph_pkg::CNT_W-1:0] TAIL_C  = ecph_pkg::CNT_W'(ecph_pkg::FIFO_TAIL_CYC);
  localparam logic [ecph_pkg::CNT_W-1:0] ECP_C   = ecph_pkg::CNT_W'(ecph_pkg::ECP_DELAY_CYC);

  // ----------------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------------
  ecph_filter #(
    .STABLE_CYC (ecph_pkg::FILTER_CYC),
    .RST_VAL    (1'h0)
  ) u_busy_filter (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .raw     (busy_in),
    .filt    (busy_f)   // R13
  );

  ecph_filter #(
    .STABLE_CYC (ecph_pkg::FILTER_CYC),
    .RST_VAL    (1'h1)
  ) u_ack_filter (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .raw     (ack_n_in),
    .filt    (ack_n_f)  // R18
  );

  // Data lines are stable well before the filtered ack moves, so plain sync suffices
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      data_sync_a <= 8'h00;
      data_sync_b <= 8'h00;
    end else begin
      data_sync_a <= port_data_lines_in;
      data_sync_b <= data_sync_a;
    end
  end

  // ----------------------------------------------------------------------
  // Mode latch
  // ----------------------------------------------------------------------
  // Mode and direction change only while idle, when every output is at rest
  // Reverse is honoured in ECP mode only
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      act_mode <= ecph_pkg::MODE_COMPAT;
      act_rev  <= 1'h0;
    end else if (state == ecph_pkg::ST_IDLE) begin
      act_mode <= mode;
      act_rev  <= reverse && (mode == ecph_pkg::MODE_ECP);
    end
  end

  assign is_fifo    = (act_mode == ecph_pkg::MODE_FIFO);
  assign is_ecp_fwd = (act_mode == ecph_pkg::MODE_ECP) && !act_rev;
  assign is_ecp_rev = (act_mode == ecph_pkg::MODE_ECP) && act_rev;
  assign cnt_done   = (cnt == '0);

  // ----------------------------------------------------------------------
  // Busy-low timer
  // ----------------------------------------------------------------------
  // Saturates at the longest gap needed, so it never wraps
  // Also times the hold tail and the ECP wait
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      busy_lo_cnt <= '0;
    end else if (busy_f) begin
      busy_lo_cnt <= '0;
    end else if (busy_lo_cnt != GAP_C) begin
      busy_lo_cnt <= busy_lo_cnt + 1'b1;  // R24
    end
  end

  // ----------------------------------------------------------------------
  // Transfer state machine
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      // Outputs rest at their idle levels
      state      <= ecph_pkg::ST_IDLE;
      cnt        <= '0;
      strobe_n   <= ecph_pkg::STROBE_N_RST;
      host_ack_n <= ecph_pkg::HOST_ACK_N_RST;
      data_q     <= ecph_pkg::DATA_RST;
      cmd_q      <= 1'h0;
    end else begin
      if (!cnt_done) begin
        cnt <= cnt - 1'b1;  // R24
      end
      case (state)
        ecph_pkg::ST_IDLE: begin
          strobe_n <= 1'h1;  // R22
          if (is_fifo) begin
            host_ack_n <= 1'h1;
            // Ack is never looked at here
            if (tx_valid && !busy_f) begin  // R21
              data_q <= tx_word.data;
              cnt    <= SETUP_C;
              state  <= ecph_pkg::ST_F_SETUP;
            end
          end else if (is_ecp_fwd) begin
            host_ack_n <= cmd_q;
            // Data, command flag and strobe move together after the busy-low wait
            if (tx_valid && busy_lo_cnt >= ECP_C) begin  // R09 R11 R12
              data_q     <= tx_word.data;
              cmd_q      <= !tx_word.cmd;
              host_ack_n <= !tx_word.cmd;
              strobe_n   <= 1'h0;
              state      <= ecph_pkg::ST_E_STROBE;
            end
          end else if (is_ecp_rev) begin
            host_ack_n <= 1'h0;  // R22
            // No room or terminal count: stay here with host ack low
            if (!ack_n_f && rx_room && !term_count) begin  // R15 R17
              cnt   <= ECP_C;
              state <= ecph_pkg::ST_R_ACK;
            end
          end else begin
            host_ack_n <= 1'h1;
          end
        end
        ecph_pkg::ST_F_SETUP: begin
          // Setup and busy-low gap must both run out
          if (cnt_done && busy_lo_cnt == GAP_C) begin  // R03 R05
            strobe_n <= 1'h0;
            cnt      <= PULSE_C;
            state    <= ecph_pkg::ST_F_STROBE;
          end
        end
        ecph_pkg::ST_F_STROBE: begin
          // Pulse width counted from the falling edge
          if (cnt_done) begin  // R04
            strobe_n <= 1'h1;
            cnt      <= HOLD_C;
            state    <= ecph_pkg::ST_F_HOLD;
          end
        end
        ecph_pkg::ST_F_HOLD: begin
          // Data may move only after both the hold time and the busy-low tail
          if (cnt_done && busy_lo_cnt >= TAIL_C) begin  // R06
            state <= ecph_pkg::ST_IDLE;
          end
        end
        ecph_pkg::ST_E_STROBE: begin
          // Busy counts only once the filter passes it
          if (busy_f) begin
            cnt   <= ECP_C;
            state <= ecph_pkg::ST_E_REL;
          end
        end
        ecph_pkg::ST_E_REL: begin
          if (cnt_done) begin  // R10
            strobe_n <= 1'h1;
            state    <= ecph_pkg::ST_IDLE;
          end
        end
        ecph_pkg::ST_R_ACK: begin
          // Answer delay, then raise host ack and take the byte
          if (host_ack_n == 1'h0) begin
            if (cnt_done) begin
              host_ack_n <= 1'h1;  // R15
              data_q     <= data_sync_b;
            end
          // Delay restarts while the peripheral holds its ack
          end else if (!ack_n_f) begin
            cnt <= ECP_C;
          // Release recognised and delay run out: close the byte
          end else if (cnt_done) begin
            host_ack_n <= 1'h0;  // R16
            state      <= ecph_pkg::ST_IDLE;
          end
        end
        default: begin
          // Unused codes return to idle, strobe released
          state    <= ecph_pkg::ST_IDLE;
          strobe_n <= 1'h1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Reverse byte delivery
  // ----------------------------------------------------------------------
  // The byte is handed over when the delay after the filtered ack release runs out, as host ack drops, one pulse per byte
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rx_valid <= 1'h0;
      rx_word  <= '0;
    end else begin
      rx_valid <= 1'h0;
      if (state == ecph_pkg::ST_R_ACK && host_ack_n && ack_n_f && cnt_done) begin
        rx_valid     <= 1'h1;
        rx_word.data <= data_q;
        rx_word.cmd  <= 1'h0;
      end
    end
  end

  // Pull the word from the FIFO in the cycle the engine latches it
  always_comb begin
    tx_ready = 1'h0;
    if (state == ecph_pkg::ST_IDLE && tx_valid) begin
      if (is_fifo) begin
        tx_ready = !busy_f;
      end else if (is_ecp_fwd) begin
        tx_ready = (busy_lo_cnt >= ECP_C);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Output drivers
  // ----------------------------------------------------------------------
  // Drive style only flips in idle, where each control sits high: open-collector
  // high (released) and push-pull high read the same, so no edge appears
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      push_pull <= 1'h0;
    end else if (state == ecph_pkg::ST_IDLE && strobe_n && host_ack_n) begin
      push_pull <= (mode == ecph_pkg::MODE_ECP);  // R01 R02
    end
  end

  // Open-collector style drives only while pulling low
  // Last latched byte stays on the lines until a new one is taken
  assign pins.data_out     = data_q;  // R07
  assign pins.data_oe      = !act_rev;
  assign pins.strobe_n_out = strobe_n;  // R23
  assign pins.strobe_n_oe  = push_pull || !strobe_n;  // R02
  assign pins.autofd_n_out = host_ack_n;  // R23
  assign pins.autofd_n_oe  = push_pull || !host_ack_n;  // R02
  assign engine_idle       = (state == ecph_pkg::ST_IDLE);

endmodule : ecph_engine

// *** tb/ecph_engine_assertions.sv ***
// Protocol checker for the parallel port handshake engine
module ecph_engine_assertions (
  input wire logic                 sys_clk,
  input wire logic                 nrst,
  input wire logic [2:0]           mode,
  input wire logic                 reverse,
  input wire logic                 tx_valid,
  input wire logic                 rx_valid,
  input wire logic                 rx_room,
  input wire logic                 term_count,
  input wire logic                 busy_in,
  input wire logic                 ack_n_in,
  input wire ecph_pkg::ecph_pins_t pins,
  input wire logic                 push_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] dcnt;
  logic [5:0] lcnt;
  logic [5:0] hcnt;
  logic [5:0] bcnt;
  logic [7:0] prev_data;
  logic       fifo;
  logic       ecpf;
  logic       ecpr;
  assign fifo = (mode == ecph_pkg::MODE_FIFO);
  assign ecpf = (mode == ecph_pkg::MODE_ECP) && !reverse;
  assign ecpr = (mode == ecph_pkg::MODE_ECP) && reverse;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  function automatic logic [5:0] inc(input logic [5:0] v);
    return (v == 6'h3f) ? v : v + 6'h01;
  endfunction : inc

  // ----------------------------------------------------------------------
  // Age counters; hold and busy-low ages saturated at reset so the first transfer is not penalised
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    prev_data <= pins.data_out;
    if (!nrst) begin
      dcnt <= 6'h00;
      lcnt <= 6'h00;
      hcnt <= 6'h3f;
      bcnt <= 6'h3f;
    end else begin
      dcnt <= (pins.data_out != prev_data) ? 6'h00 : inc(dcnt);
      lcnt <= pins.strobe_n_out ? 6'h00 : inc(lcnt);
      hcnt <= pins.strobe_n_out ? inc(hcnt) : 6'h00;
      bcnt <= busy_in ? 6'h00 : inc(bcnt);
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  // A count of 23 here means 24 whole cycles of stable data
  chk_fifo_setup: assert property ($fell(pins.strobe_n_out) && fifo |-> dcnt >= 6'h17)
    else $error("fifo data setup too short");
  chk_fifo_pulse: assert property ($rose(pins.strobe_n_out) && fifo |-> lcnt >= 6'h18)
    else $error("fifo strobe pulse too short");
  chk_fifo_gap: assert property ($fell(pins.strobe_n_out) && fifo |-> bcnt >= 6'h1c)
    else $error("fifo strobe too soon after busy");
  chk_fifo_hold: assert property ($changed(pins.data_out) && fifo |-> hcnt >= 6'h12 && bcnt >= 6'h04)
    else $error("fifo data hold too short");
  chk_fifo_keep: assert property (fifo && !tx_valid && pins.strobe_n_out && hcnt > 6'h30 |=> $stable(pins.data_out))
    else $error("idle data changed");
  chk_ecp_start: assert property ($fell(busy_in) && ecpf && tx_valid |-> ##[4:16] !pins.strobe_n_out)
    else $error("ecp strobe late");
  chk_ecp_min: assert property (($fell(pins.strobe_n_out) || $changed(pins.data_out)) && ecpf |-> bcnt >= 6'h04)
    else $error("ecp change too soon after busy");
  chk_ecp_release: assert property ((ecpf && !pins.strobe_n_out && $rose(busy_in)) ##1 busy_in[*6]
    |-> !pins.strobe_n_out ##[1:8] pins.strobe_n_out)
    else $error("ecp strobe release out of window");
  chk_rev_raise: assert property (ecpr && rx_room && !term_count && !pins.autofd_n_out && $fell(ack_n_in)
    |-> !pins.autofd_n_out[*7] ##[1:8] pins.autofd_n_out)
    else $error("host ack raise out of window");
  chk_rev_done: assert property (ecpr && pins.autofd_n_out && $rose(ack_n_in)
    |-> pins.autofd_n_out[*4] ##[1:8] (rx_valid && !pins.autofd_n_out))
    else $error("host ack drop out of window");
  chk_rev_stall: assert property (ecpr && (!rx_room || term_count) && !pins.autofd_n_out |=> !pins.autofd_n_out)
    else $error("reverse did not stall");
  chk_drive_kind: assert property (push_pull ? (pins.strobe_n_oe && pins.autofd_n_oe)
    : (pins.strobe_n_oe == !pins.strobe_n_out && pins.autofd_n_oe == !pins.autofd_n_out))
    else $error("wrong drive style");
  chk_style_swap: assert property ($changed(push_pull) |-> pins.strobe_n_out && pins.autofd_n_out)
    else $error("drive style changed mid handshake");

  cover property ($fell(pins.strobe_n_out) && fifo);
  cover property ($fell(pins.strobe_n_out) && ecpf);
  cover property (rx_valid && ecpr);
endmodule : ecph_engine_assertions

bind ecph_engine ecph_engine_assertions u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .mode(mode), .reverse(reverse), .tx_valid(tx_valid),
  .rx_valid(rx_valid), .rx_room(rx_room), .term_count(term_count), .busy_in(busy_in),
  .ack_n_in(ack_n_in), .pins(pins), .push_pull(push_pull)
);

// *** tb/ecph_periph.sv ***
// Behavioural peripheral on the far end of the parallel cable
module ecph_periph (
  input  wire logic                 sys_clk,
  input  wire ecph_pkg::ecph_pins_t pins,
  input  wire logic [3:0]           delay,
  input  wire logic                 glitch,
  input  wire logic [7:0]           rev_byte,
  input  wire logic                 rev_go,
  output logic                      busy_in,
  output logic                      ack_n_in,
  output logic [7:0]                data_lines,
  output ecph_pkg::ecph_word_t      got,
  output int                        got_cnt
);
  timeunit 1ns;
  timeprecision 1ps;

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  initial begin
    busy_in = 1'h0;
    ack_n_in = 1'h1;
    data_lines = 8'h00;
    got = '0;
    got_cnt = 0;
    forever begin
      @(negedge sys_clk);
      if (!pins.strobe_n_out) begin
        got = '{cmd: !pins.autofd_n_out, data: pins.data_out};
        got_cnt++;
        // A short bounce that a correct filter must not take as busy
        if (glitch) begin
          busy_in = 1'h1;
          cyc(2);
          busy_in = 1'h0;
          cyc(12);
        end
        cyc(delay);
        busy_in = 1'h1;
        while (!pins.strobe_n_out) @(negedge sys_clk);
        cyc(delay);
        busy_in = 1'h0;
      end else if (rev_go && !pins.autofd_n_out) begin
        data_lines = rev_byte;
        cyc(1);
        ack_n_in = 1'h0;
        while (!pins.autofd_n_out) @(negedge sys_clk);
        cyc(delay);
        ack_n_in = 1'h1;
        while (pins.autofd_n_out) @(negedge sys_clk);
        // Released lines show garbage rather than the old byte
        data_lines = ~rev_byte;
        while (rev_go) @(negedge sys_clk);
      end
    end
  end
endmodule : ecph_periph

// *** tb/ecph_engine_tb.sv ***
// Self-checking testbench for the parallel port handshake engine
module ecph_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 sys_clk;
  logic                 nrst;
  logic [2:0]           mode;
  logic                 reverse;
  logic                 tx_valid;
  ecph_pkg::ecph_word_t tx_word;
  logic                 tx_ready;
  logic                 rx_valid;
  ecph_pkg::ecph_word_t rx_word;
  logic                 rx_room;
  logic                 term_count;
  logic [7:0]           lines;
  logic                 busy;
  logic                 ack_n;
  logic                 ack_poke;
  logic                 ack_line;
  ecph_pkg::ecph_pins_t pins;
  logic                 push_pull;
  logic                 engine_idle;
  logic [3:0]           delay;
  logic                 glitch;
  logic [7:0]           rev_byte;
  logic                 rev_go;
  ecph_pkg::ecph_word_t got;
  int                   got_cnt;
  int                   errors;
  int                   samples_checked;
  assign ack_line = ack_n ^ ack_poke;

  ecph_engine DUT (
    .sys_clk(sys_clk), .nrst(nrst), .mode(mode), .reverse(reverse), .tx_valid(tx_valid), .tx_word(tx_word),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_word(rx_word), .rx_room(rx_room), .term_count(term_count),
    .port_data_lines_in(lines), .busy_in(busy), .ack_n_in(ack_line), .pins(pins), .push_pull(push_pull),
    .engine_idle(engine_idle)
  );
  ecph_periph u_periph (
    .sys_clk(sys_clk), .pins(pins), .delay(delay), .glitch(glitch), .rev_byte(rev_byte), .rev_go(rev_go),
    .busy_in(busy), .ack_n_in(ack_n), .data_lines(lines), .got(got), .got_cnt(got_cnt)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic expect_ok(input logic ok, input string what);
    samples_checked++;
    if (ok !== 1'h1) begin
      errors++;
      $display("unexpected at %0t ns: %s", $time, what);
    end
  endtask : expect_ok

  task automatic test_done();
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  // Holds the word until the edge that sees ready, then lets go
  task automatic send(input ecph_pkg::ecph_word_t w);
    tx_valid = 1'h1;
    tx_word = w;
    #1;
    while (tx_ready !== 1'h1) begin
      @(negedge sys_clk);
      #1;
    end
    @(negedge sys_clk);
    tx_valid = 1'h0;
  endtask : send

  task automatic set_mode(input logic [2:0] m, input logic r);
    while (engine_idle !== 1'h1) @(negedge sys_clk);
    mode = m;
    reverse = r;
    cyc(3);
  endtask : set_mode

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    expect_ok(pins.strobe_n_out === 1'h1 && pins.autofd_n_out === 1'h1, "idle levels");
    expect_ok(pins.data_out === 8'h00 && push_pull === 1'h0 && pins.strobe_n_oe === 1'h0, "reset drive");
  endtask : t_reset

  task automatic t_fifo();
    set_mode(ecph_pkg::MODE_FIFO, 1'h0);
    ack_poke = 1'h1;
    delay = 4'hf;
    send('{cmd: 1'h0, data: 8'ha5});
    while (got_cnt < 1) @(negedge sys_clk);
    expect_ok(got.data === 8'ha5, "first fifo byte");
    send('{cmd: 1'h1, data: 8'h3c});
    while (got_cnt < 2) @(negedge sys_clk);
    expect_ok(got.data === 8'h3c, "second fifo byte");
    cyc(100);
    expect_ok(pins.data_out === 8'h3c && pins.strobe_n_out === 1'h1, "last byte held");
    ack_poke = 1'h0;
  endtask : t_fifo

  task automatic t_ecp_fwd();
    set_mode(ecph_pkg::MODE_ECP, 1'h0);
    delay = 4'h1;
    glitch = 1'h1;
    send('{cmd: 1'h1, data: 8'h5a});
    while (got_cnt < 3) @(negedge sys_clk);
    expect_ok(got === 9'h15a, "command word");
    cyc(10);
    expect_ok(pins.strobe_n_out === 1'h0, "strobe kept through bounce");
    expect_ok(push_pull === 1'h1 && pins.data_oe === 1'h1, "push-pull drive");
    glitch = 1'h0;
    delay = 4'h6;
    send('{cmd: 1'h0, data: 8'hc3});
    cyc(2);
    expect_ok(got === 9'h0c3, "data word");
    send('{cmd: 1'h1, data: 8'h81});
    while (got_cnt < 5) @(negedge sys_clk);
    expect_ok(got === 9'h181, "back to back word");
  endtask : t_ecp_fwd

  task automatic t_ecp_rev();
    set_mode(ecph_pkg::MODE_ECP, 1'h1);
    rev_byte = 8'h96;
    rev_go = 1'h1;
    while (rx_valid !== 1'h1) @(negedge sys_clk);
    rev_go = 1'h0;
    expect_ok(rx_word === 9'h096, "reverse byte");
    cyc(2);
    rx_room = 1'h0;
    rev_byte = 8'h69;
    rev_go = 1'h1;
    cyc(40);
    expect_ok(pins.autofd_n_out === 1'h0 && pins.data_oe === 1'h0, "stall without room");
    term_count = 1'h1;
    rx_room = 1'h1;
    cyc(40);
    expect_ok(pins.autofd_n_out === 1'h0, "stall at terminal count");
    term_count = 1'h0;
    while (rx_valid !== 1'h1) @(negedge sys_clk);
    rev_go = 1'h0;
    expect_ok(rx_word === 9'h069, "byte after stall");
  endtask : t_ecp_rev

  // ----------------------------------------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial begin
    errors = 0;
    samples_checked = 0;
    nrst = 1'h0;
    mode = ecph_pkg::MODE_COMPAT;
    reverse = 1'h0;
    tx_valid = 1'h0;
    tx_word = '0;
    rx_room = 1'h1;
    term_count = 1'h0;
    ack_poke = 1'h0;
    delay = 4'h1;
    glitch = 1'h0;
    rev_byte = 8'h00;
    rev_go = 1'h0;
    cyc(10);
    nrst = 1'h1;
    cyc(2);
    t_reset();
    t_fifo();
    t_ecp_fwd();
    t_ecp_rev();
    test_done();
  end

  // The whole sequence needs well under 2000 cycles; ten times that means a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    $display("unexpected at %0t ns: run did not finish", $time);
    test_done();
  end
endmodule : ecph_engine_tb
